// ---- hdl/fxr_ext_read_reg.sv ----
`timescale 1ns/1ps
`default_nettype none
module fxr_ext_read_reg (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic CE_IN,
  input wire logic SOFT_RST_IN,
  input wire logic WR_STB_IN,
  input wire logic [7:0] WR_OP_IN,
  input wire logic [7:0] WR_DATA_IN,
  input wire logic CLEAR_ERR_IN,
  input wire logic DONE_STB_IN,
  input wire logic [3:0] DONE_OP_IN,
  input wire logic FAIL_ERASE_IN,
  input wire logic FAIL_PROGRAM_IN,
  input wire logic TARGET_PROTECTED_IN,
  input wire logic TARGET_SUSPENDED_IN,
  input wire logic TARGET_INFO_LOCKED_IN,
  input wire logic PROT_MODE_BAD_IN,
  input wire logic PASSWORD_MISMATCH_IN,
  input wire logic STATUS_LOCKED_IN,
  input wire logic BP_PROTECTED_IN,
  output logic [7:0] REG_RD_OUT,
  output logic [7:0] PERSIST_OUT,
  output logic [2:0] DRIVE_SEL_OUT,
  output logic [3:0] DRIVE_EIGHTHS_OUT,
  output logic LEARN_EN_OUT,
  output logic PROT_ERR_OUT,
  output logic PGM_ERR_OUT,
  output logic ERASE_ERR_OUT
);
  // ************************************************************
  // State
  // ************************************************************
  logic [7:0] persist;
  logic [7:0] volat;
  logic prot_flag;
  logic pgm_flag;
  logic erase_flag;
  logic next_prot;
  logic next_pgm;
  logic next_erase;
  logic load_pending;
  logic persist_fail;

  function automatic logic [3:0] drive_decode(input logic [2:0] sel);
    case (sel)
      3'h1: drive_decode = fxr_pkg::DRV_12P5;
      3'h2: drive_decode = fxr_pkg::DRV_25;
      3'h3: drive_decode = fxr_pkg::DRV_37P5;
      3'h5: drive_decode = fxr_pkg::DRV_75;
      3'h6: drive_decode = fxr_pkg::DRV_100;
      3'h7: drive_decode = fxr_pkg::DRV_50;
      default: drive_decode = fxr_pkg::DRV_NONE;
    endcase
  endfunction

  // ************************************************************
  // Persistent copy
  // ************************************************************
  // A failed NV update leaves the stored copy untouched
  assign persist_fail = FAIL_ERASE_IN | FAIL_PROGRAM_IN;

  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      persist <= fxr_pkg::NV_DEFAULT;
    end
    else if (CE_IN && WR_STB_IN && WR_OP_IN == fxr_pkg::OP_SET_PERSIST && !persist_fail)
    begin
      persist <= WR_DATA_IN & fxr_pkg::WR_MASK;
    end
  end

  // ************************************************************
  // Volatile copy
  // ************************************************************
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      load_pending <= 1'b1;
      volat <= fxr_pkg::NV_DEFAULT;
    end
    else if (CE_IN)
    begin
      if (load_pending || SOFT_RST_IN)
      begin
        load_pending <= 1'b0;
        volat <= persist;
      end
      else if (WR_STB_IN && (WR_OP_IN == fxr_pkg::OP_SET_VOLATILE
               || (WR_OP_IN == fxr_pkg::OP_SET_PERSIST && !persist_fail)))
      begin
        volat <= WR_DATA_IN & fxr_pkg::WR_MASK;
      end
    end
  end

  // ************************************************************
  // Error flag sources
  // ************************************************************
  always_comb
  begin
    next_prot = 1'b0;
    next_pgm = 1'b0;
    next_erase = 1'b0;
    if (DONE_STB_IN)
    begin
      case (fxr_pkg::fxr_op_t'(DONE_OP_IN))
        fxr_pkg::FXR_OP_PAGE_PGM:
        begin
          next_prot = TARGET_PROTECTED_IN | TARGET_SUSPENDED_IN;
          next_pgm = FAIL_PROGRAM_IN | next_prot;
        end
        fxr_pkg::FXR_OP_INFO_PGM:
        begin
          next_prot = TARGET_INFO_LOCKED_IN;
          next_pgm = FAIL_PROGRAM_IN | TARGET_INFO_LOCKED_IN;
        end
        fxr_pkg::FXR_OP_PROT_CFG:
        begin
          next_prot = PROT_MODE_BAD_IN;
          next_pgm = FAIL_PROGRAM_IN | PROT_MODE_BAD_IN;
        end
        fxr_pkg::FXR_OP_PWD_UNLOCK:
        begin
          next_prot = PASSWORD_MISMATCH_IN;
          next_pgm = PASSWORD_MISMATCH_IN;
        end
        fxr_pkg::FXR_OP_NV_REG:
        begin
          next_erase = FAIL_ERASE_IN;
          next_pgm = FAIL_PROGRAM_IN;
        end
        fxr_pkg::FXR_OP_STATUS_WR:
        begin
          next_prot = STATUS_LOCKED_IN;
          next_erase = FAIL_ERASE_IN | STATUS_LOCKED_IN;
          next_pgm = FAIL_PROGRAM_IN;
        end
        fxr_pkg::FXR_OP_FUNC_WR:
        begin
          next_pgm = FAIL_PROGRAM_IN;
        end
        fxr_pkg::FXR_OP_ERASE:
        begin
          next_prot = TARGET_PROTECTED_IN | TARGET_INFO_LOCKED_IN;
          next_erase = FAIL_ERASE_IN | next_prot;
        end
        fxr_pkg::FXR_OP_CHIP_ERASE:
        begin
          // Per-sector locks alone do not count here
          next_prot = BP_PROTECTED_IN;
          next_erase = FAIL_ERASE_IN | BP_PROTECTED_IN;
        end
        default:
        begin
          next_prot = 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // Sticky flags; a new event beats a clear in the same cycle
  // ************************************************************
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      prot_flag <= 1'b0;
      pgm_flag <= 1'b0;
      erase_flag <= 1'b0;
    end
    else if (CE_IN)
    begin
      prot_flag <= next_prot | (prot_flag & ~CLEAR_ERR_IN & ~SOFT_RST_IN);
      pgm_flag <= next_pgm | (pgm_flag & ~CLEAR_ERR_IN & ~SOFT_RST_IN);
      erase_flag <= next_erase | (erase_flag & ~CLEAR_ERR_IN & ~SOFT_RST_IN);
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      REG_RD_OUT <= 8'h00;
      PERSIST_OUT <= 8'h00;
      DRIVE_SEL_OUT <= 3'h0;
      DRIVE_EIGHTHS_OUT <= 4'h0;
      LEARN_EN_OUT <= 1'b0;
      PROT_ERR_OUT <= 1'b0;
      PGM_ERR_OUT <= 1'b0;
      ERASE_ERR_OUT <= 1'b0;
    end
    else if (CE_IN)
    begin
      REG_RD_OUT <= {volat[fxr_pkg::ODS_MSB:fxr_pkg::DLP_BIT], erase_flag, pgm_flag,
                     prot_flag, 1'b0};
      PERSIST_OUT <= persist;
      DRIVE_SEL_OUT <= volat[fxr_pkg::ODS_MSB:fxr_pkg::ODS_LSB];
      DRIVE_EIGHTHS_OUT <= drive_decode(volat[fxr_pkg::ODS_MSB:fxr_pkg::ODS_LSB]);
      LEARN_EN_OUT <= volat[fxr_pkg::DLP_BIT];
      PROT_ERR_OUT <= prot_flag;
      PGM_ERR_OUT <= pgm_flag;
      ERASE_ERR_OUT <= erase_flag;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_flags_untouched_by_set;
    @(posedge CLK_IN) disable iff (!NRST_IN)
    (CE_IN && WR_STB_IN && !DONE_STB_IN && !CLEAR_ERR_IN && !SOFT_RST_IN)
      |=> $stable({prot_flag, pgm_flag, erase_flag});
  endproperty
  a_flags_untouched_by_set: assert property (p_flags_untouched_by_set)
    else $error("Error flags changed by a register write");

  property p_reserved_zero;
    @(posedge CLK_IN) disable iff (!NRST_IN)
    REG_RD_OUT[fxr_pkg::RSVD_BIT] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved bit reads nonzero");

  property p_volatile_write;
    @(posedge CLK_IN) disable iff (!NRST_IN)
    (CE_IN && WR_STB_IN && WR_OP_IN == fxr_pkg::OP_SET_VOLATILE && !load_pending
      && !SOFT_RST_IN) ##1 CE_IN
      |=> REG_RD_OUT[7:4] == $past(WR_DATA_IN[7:4], 2);
  endproperty
  a_volatile_write: assert property (p_volatile_write)
    else $error("Volatile write not visible");

  property p_drive_decode;
    @(posedge CLK_IN) disable iff (!NRST_IN)
    (DRIVE_SEL_OUT == 3'h7) |-> DRIVE_EIGHTHS_OUT == fxr_pkg::DRV_50;
  endproperty
  a_drive_decode: assert property (p_drive_decode)
    else $error("Default drive not half strength");

  property p_sticky;
    @(posedge CLK_IN) disable iff (!NRST_IN)
    (CE_IN && pgm_flag && !CLEAR_ERR_IN && !SOFT_RST_IN) |=> pgm_flag;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("Program flag dropped without clear");

  property p_password;
    @(posedge CLK_IN) disable iff (!NRST_IN)
    (CE_IN && DONE_STB_IN && DONE_OP_IN == fxr_pkg::FXR_OP_PWD_UNLOCK && PASSWORD_MISMATCH_IN)
      |=> prot_flag && pgm_flag ##1 (!$past(CE_IN) || (PROT_ERR_OUT && PGM_ERR_OUT));
  endproperty
  a_password: assert property (p_password)
    else $error("Password mismatch not flagged");

  property p_chip_erase_asp;
    @(posedge CLK_IN) disable iff (!NRST_IN)
    (CE_IN && DONE_STB_IN && DONE_OP_IN == 4'h9 && !BP_PROTECTED_IN && !prot_flag)
      |=> !prot_flag;
  endproperty
  a_chip_erase_asp: assert property (p_chip_erase_asp)
    else $error("Chip erase flagged sector-lock protection");

  property p_locked_status;
    @(posedge CLK_IN) disable iff (!NRST_IN)
    (CE_IN && DONE_STB_IN && DONE_OP_IN == 4'h6 && STATUS_LOCKED_IN)
      |=> prot_flag && erase_flag;
  endproperty
  a_locked_status: assert property (p_locked_status)
    else $error("Locked status write not flagged");
endmodule
`default_nettype wire

// ---- hdl/fxr_pkg.sv ----
package fxr_pkg;
  // ************************************************************
  // Register layout
  // ************************************************************
  localparam int REG_W = 8;
  localparam int ODS_MSB = 7;
  localparam int ODS_LSB = 5;
  localparam int DLP_BIT = 4;
  localparam int EERR_BIT = 3;
  localparam int PERR_BIT = 2;
  localparam int PROT_BIT = 1;
  localparam int RSVD_BIT = 0;
  localparam logic [7:0] NV_DEFAULT = 8'he0;
  localparam logic [7:0] WR_MASK = 8'hf0;
  // ************************************************************
  // Opcodes
  // ************************************************************
  localparam logic [7:0] OP_SET_PERSIST = 8'h85;
  localparam logic [7:0] OP_SET_VOLATILE = 8'h83;
  // ************************************************************
  // Drive strength codes, eighths of full drive
  // ************************************************************
  localparam logic [2:0] ODS_RSVD0 = 3'h0;
  localparam logic [2:0] ODS_RSVD4 = 3'h4;
  localparam logic [3:0] DRV_12P5 = 4'h1;
  localparam logic [3:0] DRV_25 = 4'h2;
  localparam logic [3:0] DRV_37P5 = 4'h3;
  localparam logic [3:0] DRV_50 = 4'h4;
  localparam logic [3:0] DRV_75 = 4'h6;
  localparam logic [3:0] DRV_100 = 4'h8;
  localparam logic [3:0] DRV_NONE = 4'h0;
  // ************************************************************
  // Operation classes reported by the array engine
  // ************************************************************
  typedef enum logic [3:0] {
    FXR_OP_NONE = 4'h0,
    FXR_OP_PAGE_PGM = 4'h1,
    FXR_OP_INFO_PGM = 4'h2,
    FXR_OP_PROT_CFG = 4'h3,
    FXR_OP_PWD_UNLOCK = 4'h4,
    FXR_OP_NV_REG = 4'h5,
    FXR_OP_STATUS_WR = 4'h6,
    FXR_OP_FUNC_WR = 4'h7,
    FXR_OP_ERASE = 4'h8,
    FXR_OP_CHIP_ERASE = 4'h9
  } fxr_op_t;
endpackage

// ---- verification/flash_ext_read_error_register_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_ext_read_error_register_bench;
  localparam logic [7:0] V83 = fxr_pkg::OP_SET_VOLATILE;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic done_stb = 1'b0;
  logic [3:0] done_op = 4'h0;
  logic [8:0] q = 9'h000;
  logic [15:0] rnd = 16'h001b;
  logic [3:0] v = 4'he;
  logic [3:0] n = 4'he;
  logic [2:0] fl = 3'h0;
  logic [3:0] op;
  logic stb, clr, srst, ce, lrn, prt, pgm, ers;
  logic [7:0] wop, wdat, rd, pers;
  logic [2:0] dsel;
  logic [3:0] deig;
  // Qualifiers allowed per class: fe fp tp ts til pmb pwm sl bp
  logic [8:0] msk [10] = '{9'h1ff, 9'h0e0, 9'h090, 9'h088, 9'h004, 9'h180, 9'h182, 9'h080,
                           9'h150, 9'h141};
  logic [3:0] eig [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h0, 4'h6, 4'h8, 4'h4};
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  fxr_host_model i_host (.clk_in(clk), .wr_stb_out(stb), .wr_op_out(wop), .wr_data_out(wdat),
    .clear_out(clr), .soft_rst_out(srst), .ce_out(ce));
  fxr_ext_read_reg i_dut (.CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce), .SOFT_RST_IN(srst),
    .WR_STB_IN(stb), .WR_OP_IN(wop), .WR_DATA_IN(wdat), .CLEAR_ERR_IN(clr),
    .DONE_STB_IN(done_stb), .DONE_OP_IN(done_op), .FAIL_ERASE_IN(q[8]),
    .FAIL_PROGRAM_IN(q[7]), .TARGET_PROTECTED_IN(q[6]), .TARGET_SUSPENDED_IN(q[5]),
    .TARGET_INFO_LOCKED_IN(q[4]), .PROT_MODE_BAD_IN(q[3]), .PASSWORD_MISMATCH_IN(q[2]),
    .STATUS_LOCKED_IN(q[1]), .BP_PROTECTED_IN(q[0]), .REG_RD_OUT(rd), .PERSIST_OUT(pers),
    .DRIVE_SEL_OUT(dsel), .DRIVE_EIGHTHS_OUT(deig), .LEARN_EN_OUT(lrn), .PROT_ERR_OUT(prt),
    .PGM_ERR_OUT(pgm), .ERASE_ERR_OUT(ers));
  // ********
  // Expectation helpers
  // ********
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Flags raised as {erase, program, protection}
  function automatic logic [2:0] ef(input logic [3:0] o, input logic [8:0] x);
    case (o)
      4'h1: return {1'b0, x[7] | x[6] | x[5], x[6] | x[5]};
      4'h2: return {1'b0, x[7] | x[4], x[4]};
      4'h3: return {1'b0, x[7] | x[3], x[3]};
      4'h4: return {1'b0, x[2], x[2]};
      4'h5: return {x[8], x[7], 1'b0};
      4'h6: return {x[8] | x[1], x[7], x[1]};
      4'h7: return {1'b0, x[7], 1'b0};
      4'h8: return {x[8] | x[6] | x[4], 1'b0, x[6] | x[4]};
      4'h9: return {x[8] | x[0], 1'b0, x[0]};
      default: return 3'h0;
    endcase
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_all;
    repeat (3) @(posedge clk);
    #1;
    chk(rd, {v, fl, 1'b0});
    chk(pers, {n, 4'h0});
    chk({5'h0, dsel}, {5'h0, v[3:1]});
    chk({4'h0, deig}, {4'h0, eig[v[3:1]]});
    chk({4'h0, ers, pgm, prt, lrn}, {4'h0, fl, v[0]});
  endtask
  task automatic run_op(input logic [3:0] o, input logic [8:0] x);
    @(posedge clk);
    done_op <= o;
    done_stb <= 1'b1;
    q <= x;
    @(posedge clk);
    done_stb <= 1'b0;
    q <= 9'h000;
  endtask
  task automatic test_done;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ********
  // Sequence
  // ********
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      test_done;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    check_all;
    run_op(4'h4, 9'h004);
    run_op(4'h9, 9'h040);
    fl = 3'h3;
    i_host.send(2'h0, V83, 8'h0f, 1'b0);
    v = 4'h0;
    check_all;
    // Failed persistent update: both copies keep their old value
    @(posedge clk);
    q <= 9'h180;
    i_host.send(2'h0, fxr_pkg::OP_SET_PERSIST, 8'h5a, 1'b0);
    q <= 9'h000;
    check_all;
    // Event and clear on one edge: the new event wins
    fork
      run_op(4'h8, 9'h040);
      i_host.send(2'h1, 8'h00, 8'h00, 1'b0);
    join
    fl = ef(4'h8, 9'h040);
    check_all;
    for (int i = 0; i < 300; i++)
    begin
      rnd = lfsr(rnd);
      case (rnd[2:0])
        3'h0, 3'h1:
        begin
          i_host.send(2'h0, V83, rnd[15:8], 1'b0);
          v = rnd[15:12];
        end
        3'h2:
        begin
          i_host.send(2'h0, fxr_pkg::OP_SET_PERSIST, rnd[15:8], 1'b0);
          v = rnd[15:12];
          n = rnd[15:12];
        end
        3'h3, 3'h4:
        begin
          op = (rnd[11:8] > 4'h9) ? rnd[11:8] - 4'h6 : rnd[11:8];
          rnd = lfsr(rnd);
          run_op(op, rnd[8:0] & msk[op]);
          fl = fl | ef(op, rnd[8:0] & msk[op]);
        end
        3'h5:
        begin
          i_host.send(2'h1, 8'h00, 8'h00, 1'b0);
          fl = 3'h0;
        end
        3'h6:
        begin
          i_host.send(2'h2, 8'h00, 8'h00, 1'b0);
          v = n;
          fl = 3'h0;
        end
        // Enable low: the write must leave no trace
        default: i_host.send(2'h0, V83, rnd[15:8], 1'b1);
      endcase
      check_all;
    end
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    v = 4'he;
    n = 4'he;
    fl = 3'h0;
    check_all;
    test_done;
  end
endmodule
`default_nettype wire

// ---- verification/fxr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********
// Host command side
// ********
module fxr_host_model (
  input wire logic clk_in,
  output logic wr_stb_out,
  output logic [7:0] wr_op_out,
  output logic [7:0] wr_data_out,
  output logic clear_out,
  output logic soft_rst_out,
  output logic ce_out
);
  initial
  begin
    wr_stb_out = 1'b0;
    wr_op_out = 8'h00;
    wr_data_out = 8'h00;
    clear_out = 1'b0;
    soft_rst_out = 1'b0;
    ce_out = 1'b1;
  end
  // Kind 0 write, 1 clear, 2 soft reset; frz drops enable for the cycle
  task automatic send(input logic [1:0] kind, input logic [7:0] op, input logic [7:0] d,
                      input logic frz);
    @(posedge clk_in);
    wr_op_out <= op;
    wr_data_out <= d;
    wr_stb_out <= (kind == 2'h0);
    clear_out <= (kind == 2'h1);
    soft_rst_out <= (kind == 2'h2);
    ce_out <= ~frz;
    @(posedge clk_in);
    wr_stb_out <= 1'b0;
    clear_out <= 1'b0;
    soft_rst_out <= 1'b0;
    ce_out <= 1'b1;
    // Released data inverted so a stale value cannot match
    wr_data_out <= ~d;
  endtask
endmodule
`default_nettype wire
